/* File: shared/lbh_pkg.sv */
/*
 * lbh_pkg: register offsets, field layouts, reset values and enums for the
 * layer blend and horizontal timing block.
 * Assumes: a simple strobe register port, one 10 MHz system clock.
 */
package lbh_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_LAYER_POS   = 8'h00;
   localparam logic [7:0] OFS_LAYER_BG    = 8'h04;
   localparam logic [7:0] OFS_FADE_CTRL   = 8'h08;
   localparam logic [7:0] OFS_FADE_STAT   = 8'h0C;
   localparam logic [7:0] OFS_HTIME_A     = 8'h10;
   localparam logic [7:0] OFS_HTIME_B     = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT    = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h1C;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [10:0] RST_LAYER_X    = 11'h000;
   localparam logic [10:0] RST_LAYER_Y    = 11'h000;
   localparam logic [7:0]  RST_ALPHA      = 8'hFF;
   localparam logic [7:0]  RST_BG_COLOUR  = 8'hFF;
   localparam logic [7:0]  RST_FADE_SPEED = 8'h00;
   localparam logic [10:0] RST_H_TOTAL    = 11'h400;
   localparam logic [10:0] RST_H_ACTIVE   = 11'h320;
   localparam logic [10:0] RST_H_BPORCH   = 11'h02E;
   localparam logic [10:0] RST_H_SYNC     = 11'h014;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int POS_X_LSB     = 0;
   localparam int POS_Y_LSB     = 16;
   localparam int BG_B_LSB      = 0;
   localparam int BG_G_LSB      = 8;
   localparam int BG_R_LSB      = 16;
   localparam int BG_A_LSB      = 24;
   localparam int FC_MODE_LSB   = 0;
   localparam int FC_SPEED_LSB  = 8;
   localparam int FC_START_BIT  = 16;
   localparam int FC_HPOL_BIT   = 17;
   localparam int HA_TOTAL_LSB  = 0;
   localparam int HA_ACTIVE_LSB = 16;
   localparam int HB_BPORCH_LSB = 0;
   localparam int HB_SYNC_LSB   = 16;
   localparam int IRQ_FADE_BIT  = 0;
   localparam int IRQ_LINE_BIT  = 1;

   typedef enum logic [1:0] {
      FADE_NONE = 2'h0,
      FADE_IN   = 2'h1,
      FADE_OUT  = 2'h2
   } lbh_fade_mode_t;

   typedef enum logic [1:0] {
      HS_SYNC,
      HS_BACK,
      HS_ACTIVE,
      HS_FRONT
   } lbh_hstate_t;

endpackage

/* File: rtl/lbh_blend.sv */
/*
 * lbh_blend: one colour channel alpha blend, registered output.
 * Assumes: fg, bg and alpha are stable for the cycle they are sampled.
 */
`timescale 1ns/100ps
module lbh_blend (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // channel inputs
   input  wire logic [7:0] fg,
   input  wire logic [7:0] bg,
   input  wire logic [7:0] alpha,
   // blended channel
   output logic      [7:0] mix
);
   wire logic [15:0] prod_fg;
   wire logic [15:0] prod_bg;
   wire logic [16:0] sum_all;
   wire logic [7:0]  inv_alpha;

   assign inv_alpha = 8'hFF - alpha;
   assign prod_fg   = fg * alpha;
   assign prod_bg   = bg * inv_alpha;
   assign sum_all   = {1'b0, prod_fg} + {1'b0, prod_bg} + 17'h000FF;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mix <= 8'h00;
      end else begin
         mix <= sum_all[15:8];
      end
   end
endmodule

/* File: rtl/lbh_top.sv */
/*
 * lbh_top: foreground layer placement and alpha blend, frame fade engine,
 * horizontal line timing with sync polarity, register port and interrupt.
 * Assumes: one 10 MHz clock used as pixel clock, a frame start pulse from
 * vertical timing outside, and the pixel fetch supplying fg/bg pixels.
 */
// Notes on behaviour
// R01 - foreground placed at vertical offset from layer Y setting, reset 0
// R02 - foreground placed at horizontal offset from layer X setting, reset 0
// R03 - layer alpha blends foreground onto lower layer, reset 255
// R04 - separate red, green, blue background components, each reset 255
// R05 - fade-in ramps layer from transparent to opaque; fading off at reset
// R06 - fade-out ramps layer from opaque to transparent
// R07 - a started fade runs to its end and cannot be halted
// R08 - fade progress is readable by software as a status
// R09 - fade finishes over the programmed number of frames, reset 0
// R10 - each line lasts the programmed total cycles, reset 1024
// R11 - active video lasts programmed cycles per line, reset 800
// R12 - back porch counted from sync start, includes sync, reset 46
// R13 - sync asserted for programmed cycles at line start, reset 20
// R14 - sync polarity selectable, low-active by default
// R15 - remaining cycles form front porch with active video off
`timescale 1ns/100ps
module lbh_top (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // frame and pixel inputs
   input  wire logic        frame_start,
   input  wire logic [10:0] line_y,
   input  wire logic [23:0] fg_pixel,
   input  wire logic [23:0] bg_pixel,
   // panel outputs
   output logic             hsync,
   output logic             data_en,
   output logic [10:0]      pix_x,
   output logic [23:0]      pix_rgb,
   // interrupt
   output wire logic        irq
);
   // ---------------------------------------------------------------
   // reset synchroniser
   // ---------------------------------------------------------------
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [10:0] layer_x;
   logic [10:0] layer_y;
   logic [7:0]  layer_alpha;
   logic [7:0]  bg_r;
   logic [7:0]  bg_g;
   logic [7:0]  bg_b;
   logic [1:0]  fade_mode;
   logic [7:0]  fade_speed;
   logic        hs_high;
   logic [10:0] h_total;
   logic [10:0] h_active;
   logic [10:0] h_bporch;
   logic [10:0] h_sync;
   logic [1:0]  irq_stat;
   logic [1:0]  irq_mask;

   wire logic wr_pos   = reg_wr && (reg_addr == lbh_pkg::OFS_LAYER_POS);
   wire logic wr_bg    = reg_wr && (reg_addr == lbh_pkg::OFS_LAYER_BG);
   wire logic wr_fade  = reg_wr && (reg_addr == lbh_pkg::OFS_FADE_CTRL);
   wire logic wr_ha    = reg_wr && (reg_addr == lbh_pkg::OFS_HTIME_A);
   wire logic wr_hb    = reg_wr && (reg_addr == lbh_pkg::OFS_HTIME_B);
   wire logic wr_istat = reg_wr && (reg_addr == lbh_pkg::OFS_IRQ_STAT);
   wire logic wr_imask = reg_wr && (reg_addr == lbh_pkg::OFS_IRQ_MASK);

   // fade engine state
   logic        fade_busy;
   logic [7:0]  fade_frame;
   logic [1:0]  fade_dir;
   logic [7:0]  fade_alpha;
   logic        fade_done;
   logic [7:0]  run_speed;
   wire  logic  fade_start = wr_fade && reg_wdata[lbh_pkg::FC_START_BIT];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // R01 coordinates reset
         layer_x     <= lbh_pkg::RST_LAYER_X;
         layer_y     <= lbh_pkg::RST_LAYER_Y;
         layer_alpha <= lbh_pkg::RST_ALPHA;
         bg_r        <= lbh_pkg::RST_BG_COLOUR;
         bg_g        <= lbh_pkg::RST_BG_COLOUR;
         bg_b        <= lbh_pkg::RST_BG_COLOUR;
         fade_mode   <= lbh_pkg::FADE_NONE;
         fade_speed  <= lbh_pkg::RST_FADE_SPEED;
         hs_high     <= 1'b0;
         h_total     <= lbh_pkg::RST_H_TOTAL;
         h_active    <= lbh_pkg::RST_H_ACTIVE;
         h_bporch    <= lbh_pkg::RST_H_BPORCH;
         h_sync      <= lbh_pkg::RST_H_SYNC;
      end else begin
         if (wr_pos) begin
            layer_x <= reg_wdata[lbh_pkg::POS_X_LSB +: 11];
            layer_y <= reg_wdata[lbh_pkg::POS_Y_LSB +: 11];
         end
         if (wr_bg) begin
            // R04 per-channel background
            bg_b        <= reg_wdata[lbh_pkg::BG_B_LSB +: 8];
            bg_g        <= reg_wdata[lbh_pkg::BG_G_LSB +: 8];
            bg_r        <= reg_wdata[lbh_pkg::BG_R_LSB +: 8];
            layer_alpha <= reg_wdata[lbh_pkg::BG_A_LSB +: 8];
         end
         if (wr_fade) begin
            fade_mode  <= reg_wdata[lbh_pkg::FC_MODE_LSB +: 2];
            fade_speed <= reg_wdata[lbh_pkg::FC_SPEED_LSB +: 8];
            // R14 sync polarity select
            hs_high    <= reg_wdata[lbh_pkg::FC_HPOL_BIT];
         end
         if (wr_ha) begin
            h_total  <= reg_wdata[lbh_pkg::HA_TOTAL_LSB +: 11];
            h_active <= reg_wdata[lbh_pkg::HA_ACTIVE_LSB +: 11];
         end
         if (wr_hb) begin
            h_bporch <= reg_wdata[lbh_pkg::HB_BPORCH_LSB +: 11];
            h_sync   <= reg_wdata[lbh_pkg::HB_SYNC_LSB +: 11];
         end
      end
   end

   // ---------------------------------------------------------------
   // fade engine
   // ---------------------------------------------------------------
   wire logic [1:0] start_dir  = reg_wdata[lbh_pkg::FC_MODE_LSB +: 2];
   wire logic       start_ok   = fade_start && !fade_busy && (start_dir != lbh_pkg::FADE_NONE);
   // speed latched at start, so later writes cannot cut a running fade
   wire logic [7:0]  step_no   = fade_frame + 8'h01;
   wire logic       last_frame = (step_no >= run_speed);
   wire logic [15:0] ramp_mul  = {8'h00, step_no} * 16'h00FF;
   wire logic [7:0]  ramp_val  = (run_speed == 8'h00) ? 8'hFF : 8'(ramp_mul / {8'h00, run_speed});
   logic [7:0]       next_fade_alpha;

   always_comb begin
      next_fade_alpha = fade_alpha;
      if (fade_dir == lbh_pkg::FADE_IN) begin
         // R05 transparent to opaque
         next_fade_alpha = last_frame ? 8'hFF : ramp_val;
      end else if (fade_dir == lbh_pkg::FADE_OUT) begin
         // R06 opaque to transparent
         next_fade_alpha = last_frame ? 8'h00 : 8'hFF - ramp_val;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fade_busy  <= 1'b0;
         fade_frame <= 8'h00;
         fade_dir   <= lbh_pkg::FADE_NONE;
         fade_alpha <= 8'hFF;
         fade_done  <= 1'b0;
         run_speed  <= lbh_pkg::RST_FADE_SPEED;
      end else begin
         fade_done <= 1'b0;
         if (start_ok) begin
            // R07 start only when idle
            fade_busy  <= 1'b1;
            fade_frame <= 8'h00;
            fade_dir   <= start_dir;
            run_speed  <= reg_wdata[lbh_pkg::FC_SPEED_LSB +: 8];
            fade_alpha <= (start_dir == lbh_pkg::FADE_IN) ? 8'h00 : 8'hFF;
         end else if (fade_busy && frame_start) begin
            // R09 one step per frame
            fade_alpha <= next_fade_alpha;
            fade_frame <= fade_frame + 8'h01;
            if (last_frame) begin
               fade_busy <= 1'b0;
               fade_done <= 1'b1;
            end
         end
      end
   end

   AST_FADE_NO_HALT: assert property (@(posedge clk_sys) disable iff (!rst_n) // R07
      fade_busy && !(frame_start && last_frame) |=> fade_busy)
      else $error("fade stopped before its last frame");

   AST_FADE_IN_END: assert property (@(posedge clk_sys) disable iff (!rst_n) // R05
      fade_done && fade_dir == lbh_pkg::FADE_IN |-> fade_alpha == 8'hFF)
      else $error("fade-in did not end opaque");

   AST_FADE_OUT_END: assert property (@(posedge clk_sys) disable iff (!rst_n) // R06
      fade_done && fade_dir == lbh_pkg::FADE_OUT |-> fade_alpha == 8'h00)
      else $error("fade-out did not end transparent");

   // ---------------------------------------------------------------
   // horizontal timing
   // ---------------------------------------------------------------
   logic [10:0] h_cnt;
   lbh_pkg::lbh_hstate_t h_state;
   lbh_pkg::lbh_hstate_t next_h_state;
   wire logic line_end = (h_cnt + 11'h001 >= h_total);
   wire logic [10:0] act_end = h_bporch + h_active;
   logic line_done;

   always_comb begin
      next_h_state = h_state;
      unique case (h_state)
         // R13 sync at line start
         lbh_pkg::HS_SYNC:   if (h_cnt + 11'h001 >= h_sync) next_h_state = lbh_pkg::HS_BACK;
         // R12 back porch counted from sync start
         lbh_pkg::HS_BACK:   if (h_cnt + 11'h001 >= h_bporch) next_h_state = lbh_pkg::HS_ACTIVE;
         // R11 active span
         lbh_pkg::HS_ACTIVE: if (h_cnt + 11'h001 >= act_end) next_h_state = lbh_pkg::HS_FRONT;
         // R15 front porch to line end
         lbh_pkg::HS_FRONT:  next_h_state = lbh_pkg::HS_FRONT;
      endcase
      if (line_end) begin
         next_h_state = lbh_pkg::HS_SYNC;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         h_cnt     <= 11'h000;
         h_state   <= lbh_pkg::HS_SYNC;
         line_done <= 1'b0;
      end else begin
         // R10 line total
         h_cnt     <= line_end ? 11'h000 : h_cnt + 11'h001;
         h_state   <= next_h_state;
         line_done <= line_end;
      end
   end

   AST_LINE_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
      h_cnt == h_total - 11'h001 && $stable(h_total) |=> h_cnt == 11'h000)
      else $error("line did not wrap at total");

   // ---------------------------------------------------------------
   // blend and pixel output
   // ---------------------------------------------------------------
   wire logic [10:0] act_x   = h_cnt - h_bporch;
   wire logic        in_act  = (h_state == lbh_pkg::HS_ACTIVE);
   // R01 vertical placement
   wire logic        in_y    = (line_y >= layer_y);
   // R02 horizontal placement
   wire logic        in_x    = (act_x >= layer_x);
   wire logic        in_lay  = in_act && in_x && in_y;
   // R03 alpha combined with fade
   // bias keeps full alpha times full fade fully opaque
   wire logic [15:0] eff_mul = layer_alpha * fade_alpha + 16'h00FF;
   wire logic [7:0]  eff_a   = in_lay ? eff_mul[15:8] : 8'h00;
   wire logic [23:0] lower   = in_act ? bg_pixel : {bg_r, bg_g, bg_b};
   logic [23:0]      mix_rgb;
   logic             act_d;

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : g_ch
         lbh_blend u_blend (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .fg      (fg_pixel[ch*8 +: 8]),
            .bg      (lower[ch*8 +: 8]),
            .alpha   (eff_a),
            .mix     (mix_rgb[ch*8 +: 8])
         );
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hsync   <= 1'b1;
         act_d   <= 1'b0;
         data_en <= 1'b0;
         pix_x   <= 11'h000;
      end else begin
         // R14 polarity applied
         hsync   <= (h_state == lbh_pkg::HS_SYNC) ~^ hs_high;
         act_d   <= in_act;
         data_en <= in_act;
         pix_x   <= act_x;
      end
   end
   assign pix_rgb = act_d ? mix_rgb : 24'h000000;

   AST_SYNC_POL: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
      $past(rst_n) && $past(h_state) == lbh_pkg::HS_SYNC && !$past(hs_high) |-> !hsync)
      else $error("hsync polarity wrong");

   AST_FRONT_DARK: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
      h_state == lbh_pkg::HS_FRONT |=> !data_en)
      else $error("data enable high in front porch");

   AST_SYNC_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
      line_end |=> h_state == lbh_pkg::HS_SYNC ##1 (hsync == $past(hs_high)))
      else $error("sync not at line start");

   AST_ACT_AFTER_BP: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
      in_act && $stable(h_bporch) |-> h_cnt >= h_bporch)
      else $error("active before back porch end");

   AST_ACT_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
      in_act && $stable(act_end) |-> h_cnt < act_end)
      else $error("active longer than programmed");

   // ---------------------------------------------------------------
   // interrupt and read back
   // ---------------------------------------------------------------
   wire logic [1:0] irq_ev = {line_done, fade_done};
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end else begin
         irq_stat <= irq_ev | (irq_stat & ~(wr_istat ? reg_wdata[1:0] : 2'h0));
         if (wr_imask) begin
            irq_mask <= reg_wdata[1:0];
         end
      end
   end
   assign irq = |(irq_stat & irq_mask);

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (reg_addr)
         lbh_pkg::OFS_LAYER_POS: rd_mux = {5'h00, layer_y, 5'h00, layer_x};
         lbh_pkg::OFS_LAYER_BG:  rd_mux = {layer_alpha, bg_r, bg_g, bg_b};
         lbh_pkg::OFS_FADE_CTRL: rd_mux = {14'h0000, hs_high, 1'b0, fade_speed, 6'h00, fade_mode};
         // R08 fade progress readable
         lbh_pkg::OFS_FADE_STAT: rd_mux = {7'h00, fade_busy, fade_frame, fade_alpha, 6'h00, fade_dir};
         lbh_pkg::OFS_HTIME_A:   rd_mux = {5'h00, h_active, 5'h00, h_total};
         lbh_pkg::OFS_HTIME_B:   rd_mux = {5'h00, h_sync, 5'h00, h_bporch};
         lbh_pkg::OFS_IRQ_STAT:  rd_mux = {30'h00000000, irq_stat};
         lbh_pkg::OFS_IRQ_MASK:  rd_mux = {30'h00000000, irq_mask};
         default:                rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   AST_STAT_BUSY: assert property (@(posedge clk_sys) disable iff (!rst_n) // R08
      start_ok |=> fade_busy && fade_frame == 8'h00)
      else $error("fade status not shown busy after start");

   AST_FADE_FRAMES: assert property (@(posedge clk_sys) disable iff (!rst_n) // R09
      fade_done |-> $past(fade_frame) + 8'h01 >= run_speed)
      else $error("fade ended early");
endmodule

/* File: test/lbh_panel.sv */
/*
 * lbh_panel: behavioural panel that measures the horizontal line it sees.
 * Assumes: hsync and data_en launched by the block from clk_sys; pol_high
 * tells which hsync level is the asserted one.
 */
`timescale 1ns/100ps
module lbh_panel (
   // clock
   input  wire logic        clk_sys,
   // panel inputs
   input  wire logic        hsync,
   input  wire logic        data_en,
   input  wire logic        pol_high,
   // measured figures, in cycles, and the count of lines seen
   output logic      [15:0] line_len,
   output logic      [15:0] sync_len,
   output logic      [15:0] bp_len,
   output logic      [15:0] act_len,
   output logic      [15:0] line_cnt
);
   logic        sync_on;
   logic        sync_was = 1'b0;
   logic        de_was   = 1'b0;
   logic [15:0] cnt      = 16'h0000;

   assign sync_on = (hsync == pol_high);

   initial begin
      line_len = 16'h0000;
      sync_len = 16'h0000;
      bp_len   = 16'h0000;
      act_len  = 16'h0000;
      line_cnt = 16'h0000;
   end

   // cnt is 1 in the first cycle of sync, so each figure is a plain count
   always @(posedge clk_sys) begin
      sync_was <= sync_on;
      de_was   <= data_en;
      if (sync_on && !sync_was) begin
         line_len <= cnt;
         cnt      <= 16'h0001;
         line_cnt <= line_cnt + 16'h0001;
      end else begin
         cnt <= cnt + 16'h0001;
      end
      if (!sync_on && sync_was) begin
         sync_len <= cnt;
      end
      if (data_en && !de_was) begin
         bp_len <= cnt;
      end
      if (!data_en && de_was) begin
         act_len <= cnt - bp_len;
      end
   end
endmodule

/* File: test/testbench.sv */
/*
 * testbench: register, fade, blend and line timing checks for lbh_top.
 * Assumes: 10 MHz clock, bench drives frame starts and pixel inputs.
 */
`timescale 1ns/100ps
module testbench;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        frame_start = 1'b0;
   logic [10:0] line_y = 11'h000;
   logic [23:0] fg_pixel = 24'hF0A050;
   logic [23:0] bg_pixel = 24'h0F1E2D;
   logic        hsync;
   logic        data_en;
   logic [10:0] pix_x;
   logic [23:0] pix_rgb;
   logic        irq;
   logic        pol_high = 1'b0;
   logic [15:0] line_len;
   logic [15:0] sync_len;
   logic [15:0] bp_len;
   logic [15:0] act_len;
   logic [15:0] line_cnt;
   int          err_count = 0;
   int          comparisons = 0;

   always #50 clk_sys = ~clk_sys;

   lbh_top uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
      .line_y(line_y), .fg_pixel(fg_pixel), .bg_pixel(bg_pixel), .hsync(hsync),
      .data_en(data_en), .pix_x(pix_x), .pix_rgb(pix_rgb), .irq(irq));

   lbh_panel panel (.clk_sys(clk_sys), .hsync(hsync), .data_en(data_en), .pol_high(pol_high),
      .line_len(line_len), .sync_len(sync_len), .bp_len(bp_len), .act_len(act_len),
      .line_cnt(line_cnt));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic timeout;
      err_count++;
      $display("wrong value at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      final_report();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      #1;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata & m, exp);
   endtask

   task automatic frame;
      @(posedge clk_sys);
      frame_start <= 1'b1;
      @(posedge clk_sys);
      frame_start <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic wait_lines(input int n);
      logic [15:0] start;
      int          i;
      start = line_cnt;
      for (i = 0; i < n * 2100 && (line_cnt - start) < n; i++) @(posedge clk_sys);
      if ((line_cnt - start) < n) timeout();
   endtask

   task automatic px_chk(input logic [10:0] x, input logic [23:0] exp, input logic same);
      int i;
      for (i = 0; i < 2100; i++) begin
         @(posedge clk_sys);
         #1;
         if (data_en === 1'b1 && pix_x === x) break;
      end
      if (i == 2100) timeout();
      chk({31'h0, (pix_rgb === exp)}, {31'h0, same});
   endtask

   task automatic line_chk(input logic [15:0] tot, act, bp, sy);
      wait_lines(3);
      chk({16'h0, line_len}, {16'h0, tot});
      chk({16'h0, act_len}, {16'h0, act});
      chk({16'h0, bp_len}, {16'h0, bp});
      chk({16'h0, sync_len}, {16'h0, sy});
      chk({16'h0, line_len - bp_len - act_len}, {16'h0, tot - bp - act});
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rc(lbh_pkg::OFS_LAYER_POS, 32'hFFFFFFFF, 32'h00000000);
      rc(lbh_pkg::OFS_LAYER_BG, 32'hFFFFFFFF, 32'hFFFFFFFF);
      rc(lbh_pkg::OFS_HTIME_A, 32'hFFFFFFFF, 32'h03200400);
      rc(lbh_pkg::OFS_HTIME_B, 32'hFFFFFFFF, 32'h0014002E);
      rc(lbh_pkg::OFS_FADE_STAT, 32'h01000003, 32'h00000000);
      rc(lbh_pkg::OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h00000000);
      rc(8'h40, 32'hFFFFFFFF, 32'h00000000);
      chk({31'h0, irq}, 32'h0);
      $display("test reset values done");
      line_chk(16'd1024, 16'd800, 16'd46, 16'd20);
      $display("test default line done");
      wr(lbh_pkg::OFS_FADE_CTRL, 32'h00010002);
      rc(lbh_pkg::OFS_FADE_STAT, 32'h0100FF03, 32'h0100FF02);
      frame();
      rc(lbh_pkg::OFS_FADE_STAT, 32'h0100FF00, 32'h00000000);
      wr(lbh_pkg::OFS_FADE_CTRL, 32'h00010301);
      rc(lbh_pkg::OFS_FADE_STAT, 32'h0100FF03, 32'h01000001);
      wr(lbh_pkg::OFS_FADE_CTRL, 32'h00010000);
      wr(lbh_pkg::OFS_FADE_CTRL, 32'h00010002);
      frame();
      frame();
      rc(lbh_pkg::OFS_FADE_STAT, 32'h01000003, 32'h01000001);
      frame();
      rc(lbh_pkg::OFS_FADE_STAT, 32'h0100FF00, 32'h0000FF00);
      rc(lbh_pkg::OFS_IRQ_STAT, 32'h00000001, 32'h00000001);
      chk({31'h0, irq}, 32'h0);
      wr(lbh_pkg::OFS_IRQ_MASK, 32'h00000001);
      chk({31'h0, irq}, 32'h1);
      wr(lbh_pkg::OFS_IRQ_STAT, 32'h00000001);
      chk({31'h0, irq}, 32'h0);
      $display("test fade and interrupt done");
      wr(lbh_pkg::OFS_LAYER_POS, 32'h00050014);
      line_y <= 11'h002;
      px_chk(11'h028, bg_pixel, 1'b1);
      line_y <= 11'h006;
      px_chk(11'h005, bg_pixel, 1'b1);
      px_chk(11'h028, bg_pixel, 1'b0);
      px_chk(11'h028, fg_pixel, 1'b1);
      for (int i = 0; i < 2100 && data_en !== 1'b0; i++) @(posedge clk_sys);
      if (data_en !== 1'b0) timeout();
      repeat (3) @(posedge clk_sys);
      #1;
      chk({8'h0, pix_rgb}, 32'h0);
      wr(lbh_pkg::OFS_LAYER_BG, 32'h00123456);
      rc(lbh_pkg::OFS_LAYER_BG, 32'hFFFFFFFF, 32'h00123456);
      px_chk(11'h028, bg_pixel, 1'b1);
      $display("test placement and blend done");
      wr(lbh_pkg::OFS_HTIME_A, 32'h00320064);
      wr(lbh_pkg::OFS_HTIME_B, 32'h0004000C);
      wr(lbh_pkg::OFS_FADE_CTRL, 32'h00020000);
      pol_high <= 1'b1;
      line_chk(16'd100, 16'd50, 16'd12, 16'd4);
      $display("test short line high sync done");
      final_report();
   end
endmodule
